// [bench/dwdt_props.sv]
`timescale 1ns/10ps
`default_nettype none
module dwdt_props (
  input wire logic clk_sys, // Clock.
  input wire logic srst, // Reset.
  input wire logic [11:0] paddr, // Address.
  input wire logic psel, // Select.
  input wire logic penable, // Access.
  input wire logic pwrite, // Direction.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pslverr, // Error.
  input wire logic power_save, // Sleep.
  input wire logic reset_control_reg_clear, // Flag clear.
  input wire logic wdt_reset, // Reset request.
  input wire logic wake, // Wake.
  input wire logic watchdog_timeout_flag, // Flag.
  input wire logic irq // Interrupt.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr) else $error("no err");
  a_unmapped_zero: assert property (s_rd ##0 !mapped |-> prdata == 32'h0) else $error("bad rd");
  a_key_reads_zero: assert property (s_rd ##0 paddr == 12'h004 |-> prdata == 32'h0)
    else $error("key rd");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !wdt_reset && !wake && !irq)
    else $error("busy in reset");
  a_flag_rise: assert property ($rose(watchdog_timeout_flag) |-> wdt_reset)
    else $error("flag rise");
  a_flag_with_rst: assert property (wdt_reset |-> watchdog_timeout_flag)
    else $error("flag low");
  a_flag_sticky: assert property (watchdog_timeout_flag && !reset_control_reg_clear |=> watchdog_timeout_flag)
    else $error("flag lost");
  a_flag_clear: assert property (reset_control_reg_clear |=> !watchdog_timeout_flag || wdt_reset)
    else $error("flag kept");
  a_wake_sleep: assert property (wake |-> $past(power_save)) else $error("wake in run");
endmodule
bind dwdt_top dwdt_props dwdt_props_inst (.*);
`default_nettype wire

// [bench/dwdt_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module dwdt_top_tb;
  localparam logic [11:0] CL = dwdt_pkg::ADDR_CTRL_LOW;
  localparam logic [11:0] ST = dwdt_pkg::ADDR_IRQ_STAT;
  logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_d;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, cfg_enable = 1'b0, cfg_window = 1'b0, low_power_rc_osc_on = 1'b0, err_d;
  logic [4:0] cfg_run_postscale = 5'h03, cfg_sleep_postscale = 5'h02;
  logic [1:0] cfg_run_clock_select = 2'b00, ph = 2'h0;
  logic low_power_rc_osc_tick = 1'b0, frc_tick = 1'b0, power_save = 1'b0, clock_switch = 1'b0;
  logic reset_control_reg_clear = 1'b0, wdt_reset, wake, watchdog_timeout_flag, irq;
  int n_mismatch = 0, checks = 0, n_rst = 0, n_wake = 0, cyc = 0, base;
  always #5 clk_sys = ~clk_sys;
  dwdt_top dwdt_top_inst (.*);
  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Each transfer ends with an idle edge so the next setup never overwrites the release.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_d = prdata;
    err_d = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(rd_d, e);
  endtask
  always @(posedge clk_sys) begin
    ph <= ph + 2'h1;
    low_power_rc_osc_tick <= low_power_rc_osc_on && ph == 2'h3;
    frc_tick <= ph[0];
    cyc <= cyc + 1;
    if (wdt_reset === 1'b1) n_rst <= n_rst + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    reset_control_reg_clear <= 1'b1;
    @(posedge clk_sys);
    reset_control_reg_clear <= 1'b0;
    rd(CL, 32'h0000_0304);
    rd(12'h020, 32'h0);
    check({31'h0, err_d}, 32'h1);
    rd(dwdt_pkg::ADDR_CTRL_HIGH, 32'h0);
    xfer(dwdt_pkg::ADDR_IRQ_EN, 1'b1, 32'h0000_0007);
    xfer(CL, 1'b1, 32'h0000_8000);
    rd(CL, 32'h0000_8304);
    repeat (12) xfer(dwdt_pkg::ADDR_CTRL_HIGH, 1'b1, {16'h0, dwdt_pkg::CLEAR_KEY});
    check(n_rst, 0);
    repeat (20) @(posedge clk_sys);
    check({31'h0, n_rst != 0}, 32'h1);
    check({31'h0, watchdog_timeout_flag}, 32'h1);
    check({31'h0, irq}, 32'h1);
    xfer(ST, 1'b0, 32'h0);
    check(rd_d & 32'h1, 32'h1);
    xfer(CL, 1'b1, 32'h0);
    xfer(dwdt_pkg::ADDR_IRQ_CLR, 1'b1, 32'h0000_0007);
    rd(ST, 32'h0);
    check({31'h0, irq}, 32'h0);
    reset_control_reg_clear <= 1'b1;
    @(posedge clk_sys);
    reset_control_reg_clear <= 1'b0;
    @(posedge clk_sys);
    check({31'h0, watchdog_timeout_flag}, 32'h0);
    cfg_run_postscale <= 5'h04;
    base = n_rst;
    xfer(CL, 1'b1, 32'h0000_8001);
    xfer(dwdt_pkg::ADDR_CTRL_HIGH, 1'b1, {16'h0, dwdt_pkg::CLEAR_KEY});
    rd(CL, 32'h0000_8405);
    check({31'h0, n_rst > base}, 32'h1);
    xfer(ST, 1'b0, 32'h0);
    check(rd_d & 32'h4, 32'h4);
    xfer(CL, 1'b1, 32'h0);
    cfg_window <= 1'b1;
    rd(CL, 32'h0000_0405);
    cfg_enable <= 1'b1;
    power_save <= 1'b1;
    base = n_wake;
    repeat (40) @(posedge clk_sys);
    check(n_wake, base);
    low_power_rc_osc_on <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check({31'h0, n_wake != base}, 32'h1);
    rd(CL, 32'h0000_8405);
    wrap_up();
  end
endmodule
`default_nettype wire

// [core/dwdt_counter.sv]
`timescale 1ns/10ps
`default_nettype none
// One 32-bit watchdog counter with a power-of-two terminal count.
module dwdt_counter (
  input wire logic clk_sys, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic tick, // Counting enable pulse.
  input wire logic restart, // Return to zero.
  input wire logic [4:0] post, // Postscale exponent.
  output logic expire, // Terminal count reached, one pulse.
  output logic win_open // Counter in its last quarter.
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] last;
  logic [32:0] span;

  always_comb begin
    span = 33'h0_0000_0001 << post;
    last = span[31:0] - 32'h0000_0001;
    win_open = (cnt_r >= (last - (last >> 2)));
    expire = tick && (cnt_r == last) && !restart;
    cnt_nxt = cnt_r;
    if (restart || expire) begin
      cnt_nxt = 32'h0000_0000;
    end else if (tick) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// [core/dwdt_pkg.sv]
package dwdt_pkg;
  localparam logic [11:0] ADDR_CTRL_LOW = 12'h000;
  localparam logic [11:0] ADDR_CTRL_HIGH = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h010;
  localparam logic [15:0] CLEAR_KEY = 16'h5743;
  localparam int ON_BIT = 15;
  localparam int RUN_DIV_LSB = 8;
  localparam int CLK_SEL_LSB = 6;
  localparam int SLP_DIV_LSB = 1;
  localparam int WIN_BIT = 0;
  localparam logic [1:0] CLK_SEL_SYS = 2'b00;
  localparam logic [1:0] CLK_SEL_FAST = 2'b10;
  localparam logic [1:0] CLK_SEL_LOW_POWER_RC_OSC = 2'b11;
  localparam int EV_RUN_TO = 0;
  localparam int EV_SLP_WAKE = 1;
  localparam int EV_EARLY = 2;
  localparam int EV_N = 3;
  localparam logic [2:0] IRQ_RST = 3'b000;
  localparam logic RESET_SW_ON = 1'b0;
  localparam logic RESET_SW_WIN = 1'b0;
  localparam logic RESET_TO_FLAG = 1'b0;
endpackage

// [core/dwdt_top.sv]
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dwdt_top (
  input wire logic clk_sys, // 100 MHz system clock.
  input wire logic srst, // Synchronous reset, high.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped access.
  input wire logic cfg_enable, // Configuration enable.
  input wire logic cfg_window, // Configuration window mode.
  input wire logic [4:0] cfg_run_postscale, // Configuration run postscaler.
  input wire logic [4:0] cfg_sleep_postscale, // Configuration sleep postscaler.
  input wire logic [1:0] cfg_run_clock_select, // Configuration run clock source.
  input wire logic low_power_rc_osc_tick, // Low-power RC oscillator pulse.
  input wire logic frc_tick, // Fast RC oscillator pulse.
  input wire logic power_save, // Device in Sleep or Idle.
  input wire logic clock_switch, // System clock switch pulse.
  input wire logic reset_control_reg_clear, // Reset controller clears the flag.
  output logic wdt_reset, // Device reset request pulse.
  output logic wake, // Wake-up pulse.
  output logic watchdog_timeout_flag, // Flag in reset control register.
  output logic irq // Interrupt level.
);
  logic sw_on_r, sw_on_nxt;
  logic sw_win_r, sw_win_nxt;
  logic flag_r, flag_nxt;
  logic [dwdt_pkg::EV_N-1:0] stat_r, stat_nxt, en_r, en_nxt, ev;
  logic [31:0] prdata_r, prdata_nxt;
  logic rst_r, rst_nxt, wake_r, wake_nxt;
  logic acc, wr, rd, mapped, key_ok, active, win_mode, run_tick, slp_tick;
  logic run_exp, slp_exp, run_win, restart, early;
  logic [15:0] ctl_low;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == dwdt_pkg::ADDR_CTRL_LOW) || (paddr == dwdt_pkg::ADDR_CTRL_HIGH)
               || (paddr == dwdt_pkg::ADDR_IRQ_STAT) || (paddr == dwdt_pkg::ADDR_IRQ_EN)
               || (paddr == dwdt_pkg::ADDR_IRQ_CLR);
  assign pslverr = acc && !mapped;

  assign active = cfg_enable || sw_on_r;
  assign win_mode = cfg_window || sw_win_r;
  // Only a full 16-bit write of the key counts; byte writes are ignored.
  assign key_ok = wr && (paddr == dwdt_pkg::ADDR_CTRL_HIGH) && (pstrb[1:0] == 2'b11)
               && (pwdata[15:0] == dwdt_pkg::CLEAR_KEY);
  assign early = key_ok && active && win_mode && !power_save && !run_win;

  always_comb begin
    // Run source choice; the reserved code never ticks.
    unique case (cfg_run_clock_select)
      dwdt_pkg::CLK_SEL_SYS: run_tick = 1'b1;
      dwdt_pkg::CLK_SEL_FAST: run_tick = frc_tick;
      dwdt_pkg::CLK_SEL_LOW_POWER_RC_OSC: run_tick = low_power_rc_osc_tick;
      default: run_tick = 1'b0;
    endcase
    run_tick = run_tick && active && !power_save;
    slp_tick = low_power_rc_osc_tick && active && power_save;
  end

  assign restart = (key_ok && !early) || clock_switch || !active;

  dwdt_counter u_run (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick(run_tick),
    .restart(restart),
    .post(cfg_run_postscale),
    .expire(run_exp),
    .win_open(run_win)
  );

  dwdt_counter u_slp (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick(slp_tick),
    .restart(restart),
    .post(cfg_sleep_postscale),
    .expire(slp_exp),
    .win_open()
  );

  assign ev[dwdt_pkg::EV_RUN_TO] = run_exp;
  assign ev[dwdt_pkg::EV_SLP_WAKE] = slp_exp;
  assign ev[dwdt_pkg::EV_EARLY] = early;

  assign ctl_low = {active, 2'b00, cfg_run_postscale, cfg_run_clock_select,
                    cfg_sleep_postscale, win_mode};

  always_comb begin
    sw_on_nxt = sw_on_r;
    sw_win_nxt = sw_win_r;
    en_nxt = en_r;
    if (wr && paddr == dwdt_pkg::ADDR_CTRL_LOW && pstrb[1]) begin
      // A software clear cannot stop a configuration-enabled watchdog.
      sw_on_nxt = pwdata[dwdt_pkg::ON_BIT] && !cfg_enable;
    end
    if (wr && paddr == dwdt_pkg::ADDR_CTRL_LOW && pstrb[0]) begin
      sw_win_nxt = pwdata[dwdt_pkg::WIN_BIT];
    end
    if (wr && paddr == dwdt_pkg::ADDR_IRQ_EN && pstrb[0]) begin
      en_nxt = pwdata[dwdt_pkg::EV_N-1:0];
    end
    stat_nxt = stat_r;
    if (wr && paddr == dwdt_pkg::ADDR_IRQ_CLR && pstrb[0]) begin
      stat_nxt = stat_r & ~pwdata[dwdt_pkg::EV_N-1:0];
    end
    stat_nxt = stat_nxt | ev;
    rst_nxt = run_exp || early;
    wake_nxt = slp_exp;
    flag_nxt = (flag_r && !reset_control_reg_clear) || rst_nxt;
    prdata_nxt = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        dwdt_pkg::ADDR_CTRL_LOW: prdata_nxt = {16'h0000, ctl_low};
        dwdt_pkg::ADDR_IRQ_STAT: prdata_nxt = {29'h0000_0000, stat_r};
        dwdt_pkg::ADDR_IRQ_EN: prdata_nxt = {29'h0000_0000, en_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw_on_r <= dwdt_pkg::RESET_SW_ON;
      sw_win_r <= dwdt_pkg::RESET_SW_WIN;
      en_r <= dwdt_pkg::IRQ_RST;
      stat_r <= dwdt_pkg::IRQ_RST;
      rst_r <= 1'b0;
      wake_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      sw_on_r <= sw_on_nxt;
      sw_win_r <= sw_win_nxt;
      en_r <= en_nxt;
      stat_r <= stat_nxt;
      rst_r <= rst_nxt;
      wake_r <= wake_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // The flag must survive the device reset it reports, so srst leaves it alone.
  always_ff @(posedge clk_sys) begin
    flag_r <= flag_nxt;
  end

  // Read data is combinational from the current state since pready is always high.
  assign prdata = rd ? prdata_nxt : prdata_r;
  assign wdt_reset = rst_r;
  assign wake = wake_r;
  assign watchdog_timeout_flag = flag_r;
  assign irq = |(stat_r & en_r);
endmodule
`default_nettype wire
